// ==== rub_pkg.sv ====
// Constants, register map and carrier types for the receive buffer and status block.
//
// Operation
// - Receive-complete flag is one while unread characters remain, zero when empty.
// - Clearing receiver enable empties the buffer, dropping unread characters.
// - Interrupt request stays asserted while its enable and receive-complete are set.
// - Framing, overrun and parity flags travel with their frame; status shows head.
// - Software writes to error flag positions are ignored.
// - Error flags never raise an interrupt.
// - Framing error is one when first stop bit was zero, else zero.
// - Only the first stop bit is checked; stop bits setting has no effect.
// - Buffer holds two; overrun is full buffer, waiting frame, new start.
// - After overrun the next frame read shows the overrun flag set.
// - Overrun flag clears when a frame moves into the buffer successfully.
// - Parity checker works only with parity enable; odd select picks the type.
// - Parity of data bits is compared with parity bit and stored with frame.
// - Parity error only on mismatch with checking enabled; valid until data read.
// - Parity error reads zero whenever parity checking is disabled.
// - Disabling stops the receiver at once, abandoning reception in progress.
// - While disabled the receiver stops overriding the serial input pin.
// - A frame moves to the buffer at its first stop bit; second is ignored.
// - Unused upper data bits of short frames read as zero.
package rub_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CHAR_W = 9;
    localparam int unsigned DEPTH = 2;
    // Register byte addresses.
    localparam logic [3:0] ADDR_STATUS_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h4;
    localparam logic [3:0] ADDR_CTRL_C = 4'h8;
    localparam logic [3:0] ADDR_DATA = 4'hC;
    // Status register a fields.
    localparam int unsigned ST_RXC = 7;
    localparam int unsigned ST_FE = 4;
    localparam int unsigned ST_DOR = 3;
    localparam int unsigned ST_PE = 2;
    // Control register b fields.
    localparam int unsigned CB_IRQ_EN = 7;
    localparam int unsigned CB_RX_EN = 4;
    localparam int unsigned CB_NINTH = 1;
    // Control register c fields.
    localparam int unsigned CC_PAR_EN = 5;
    localparam int unsigned CC_PAR_ODD = 4;
    localparam int unsigned CC_STOP_SEL = 3;
    localparam int unsigned CC_SIZE_LO = 0;
    localparam logic [2:0] CHAR_SIZE_RST = 3'h3;
    // Character size codes and the data masks they select.
    localparam logic [2:0] SIZE_5 = 3'h0;
    localparam logic [2:0] SIZE_6 = 3'h1;
    localparam logic [2:0] SIZE_7 = 3'h2;
    localparam logic [2:0] SIZE_9 = 3'h7;
    localparam logic [8:0] MASK_5 = 9'h01F;
    localparam logic [8:0] MASK_6 = 9'h03F;
    localparam logic [8:0] MASK_7 = 9'h07F;
    localparam logic [8:0] MASK_8 = 9'h0FF;
    localparam logic [8:0] MASK_9 = 9'h1FF;
    localparam logic [1:0] COUNT_FULL = 2'h2;

    // A completed frame as delivered by the receive shift register.
    typedef struct packed {
        logic [CHAR_W-1:0] data;
        logic stop_bit;
        logic parity_bit;
    } rub_frame_t;

    // One buffer entry: character plus its own status flags.
    typedef struct packed {
        logic [CHAR_W-1:0] data;
        logic fe;
        logic dor;
        logic pe;
    } rub_entry_t;
endpackage

// ==== rub_rx_buffer.sv ====
// Two-entry receive buffer with per-frame error flags, parity check and register port.
`timescale 1ns/100ps
`default_nettype none
module rub_rx_buffer
    import rub_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata_q,
    input wire logic frame_valid,
    input wire rub_frame_t frame_in,
    input wire logic start_detect,
    input wire logic serial_input_pin,
    output logic rx_line_q,
    output logic pin_override_q,
    output logic rx_enabled_q,
    output logic rx_irq_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers.

    logic irq_en_q;
    logic rx_en_q;
    logic par_en_q;
    logic par_odd_q;
    logic stop_sel_q;
    logic [2:0] char_size_q;
    logic wr_b;
    logic wr_c;

    assign wr_b = wr_stb && (addr == ADDR_CTRL_B);
    assign wr_c = wr_stb && (addr == ADDR_CTRL_C);

    // Software-written control bits; the ninth bit position in b is read only.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_en_q <= 1'b0;
            rx_en_q <= 1'b0;
            par_en_q <= 1'b0;
            par_odd_q <= 1'b0;
            stop_sel_q <= 1'b0;
            char_size_q <= CHAR_SIZE_RST;
        end else begin
            if (wr_b) begin
                irq_en_q <= wdata[CB_IRQ_EN];
                rx_en_q <= wdata[CB_RX_EN];
            end
            if (wr_c) begin
                par_en_q <= wdata[CC_PAR_EN];
                par_odd_q <= wdata[CC_PAR_ODD];
                // Stored for software only; the stop check never looks at it.
                stop_sel_q <= wdata[CC_STOP_SEL];
                char_size_q <= wdata[CC_SIZE_LO +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and pin ownership.

    logic line_meta_q;

    // The first stage feeds only the second; the line is then handed on.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            line_meta_q <= 1'b1;
            rx_line_q <= 1'b1;
        end else begin
            line_meta_q <= serial_input_pin;
            rx_line_q <= line_meta_q;
        end
    end

    // The pin is claimed only while enabled; the framing logic is told of a disable one cycle later.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_override_q <= 1'b0;
            rx_enabled_q <= 1'b0;
        end else begin
            pin_override_q <= rx_en_q;
            rx_enabled_q <= rx_en_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame conversion into a buffer entry.

    logic [8:0] size_mask;
    rub_entry_t new_entry;

    // Reserved size codes fall back to eight bits.
    always_comb begin
        unique case (char_size_q)
            SIZE_5: size_mask = MASK_5;
            SIZE_6: size_mask = MASK_6;
            SIZE_7: size_mask = MASK_7;
            SIZE_9: size_mask = MASK_9;
            default: size_mask = MASK_8;
        endcase
    end

    // Parity settings are those in force when the frame arrives, so a later
    // change of mode does not rewrite what was already checked.
    always_comb begin
        new_entry.data = frame_in.data & size_mask;
        new_entry.fe = ~frame_in.stop_bit;
        new_entry.pe = par_en_q &&
            (^(frame_in.data & size_mask) ^ frame_in.parity_bit ^ par_odd_q);
        new_entry.dor = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer, waiting frame and overrun tracking.

    rub_entry_t buf_q [DEPTH];
    rub_entry_t hold_q;
    rub_entry_t push_entry;
    rub_entry_t head;
    logic hold_v_q;
    logic dor_pend_q;
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic [1:0] count_q;
    logic pop;
    logic space;
    logic push;
    logic take_hold;
    logic frame_ok;
    logic ovr_evt;

    assign head = buf_q[rd_ptr_q];
    assign frame_ok = rx_en_q && frame_valid;
    assign pop = rd_stb && (addr == ADDR_DATA) && (count_q != 2'h0);
    assign space = (count_q != COUNT_FULL) || pop;
    assign take_hold = hold_v_q && space;
    // A waiting frame may still be held for one cycle after disabling, so it is gated too.
    assign push = space && ((rx_en_q && hold_v_q) || frame_ok);
    // Full buffer, a frame waiting and a fresh start bit: the waiting one is lost.
    assign ovr_evt = rx_en_q && start_detect && hold_v_q && !space;

    // The waiting frame is always older than one arriving now, so it goes first.
    always_comb begin
        push_entry = take_hold ? hold_q : new_entry;
        push_entry.dor = dor_pend_q;
    end

    // Entries carry their own flags so status follows the head.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            buf_q[wr_ptr_q] <= push_entry;
        end
    end

    // Pointers and fill level; disabling flushes everything.
    always_ff @(posedge ref_clk) begin
        if (rst || !rx_en_q) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end

    // The shift register's finished frame waits here while the buffer is full.
    always_ff @(posedge ref_clk) begin
        if (rst || !rx_en_q) begin
            hold_v_q <= 1'b0;
        end else if (frame_valid && (take_hold || !space)) begin
            hold_v_q <= 1'b1;
            hold_q <= new_entry;
        end else if (take_hold || ovr_evt) begin
            hold_v_q <= 1'b0;
        end
    end

    // A successful transfer clears the pending overrun, but a new overrun wins.
    always_ff @(posedge ref_clk) begin
        if (rst || !rx_en_q) begin
            dor_pend_q <= 1'b0;
        end else if (ovr_evt) begin
            dor_pend_q <= 1'b1;
        end else if (push) begin
            dor_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port and interrupt request.

    logic [DATA_W-1:0] rd_mux;
    logic rxc;

    assign rxc = (count_q != 2'h0);

    // Error flags only show for a real head entry; writes never reach them.
    always_comb begin
        rd_mux = '0;
        unique case (addr)
            ADDR_STATUS_A: begin
                rd_mux[ST_RXC] = rxc;
                rd_mux[ST_FE] = rxc && head.fe;
                rd_mux[ST_DOR] = rxc && head.dor;
                rd_mux[ST_PE] = rxc && head.pe && par_en_q;
            end
            ADDR_CTRL_B: begin
                rd_mux[CB_IRQ_EN] = irq_en_q;
                rd_mux[CB_RX_EN] = rx_en_q;
                rd_mux[CB_NINTH] = rxc && head.data[CHAR_W-1];
            end
            ADDR_CTRL_C: begin
                rd_mux[CC_PAR_EN] = par_en_q;
                rd_mux[CC_PAR_ODD] = par_odd_q;
                rd_mux[CC_STOP_SEL] = stop_sel_q;
                rd_mux[CC_SIZE_LO +: 3] = char_size_q;
            end
            ADDR_DATA: rd_mux = rxc ? head.data[DATA_W-1:0] : '0;
            default: rd_mux = '0;
        endcase
    end

    // Read data stand for the cycle after the strobe only.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_stb ? rd_mux : '0;
        end
    end

    // Level request, one cycle behind; no error flag takes part.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= irq_en_q && rxc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // A data read that frees one place with no refill in the same cycle.
    sequence s_data_read;
        pop && !push;
    endsequence

    // An overrun followed by the pending mark one cycle later.
    sequence s_overrun;
        ovr_evt ##1 dor_pend_q;
    endsequence

    // A frame from the shift register going straight into the buffer.
    sequence s_new_frame;
        push && !take_hold;
    endsequence

    // Disabling must leave nothing readable behind.
    a_flush_on_disable: assert property (!rx_en_q |=> count_q == 2'h0)
        else $error("buffer not flushed while disabled");

    // The request is a level, not a pulse, while the flag stays set.
    a_irq_level: assert property ((irq_en_q && rxc) [*2] |=> rx_irq_q)
        else $error("interrupt request dropped while pending");

    // Only the receive-complete flag and its enable can raise the request.
    a_irq_cause: assert property (rx_irq_q |-> $past(rxc) && $past(irq_en_q))
        else $error("interrupt request without receive complete");

    // An empty buffer never requests, whatever error flags the head once had.
    a_irq_source: assert property (!rxc |=> !rx_irq_q)
        else $error("interrupt request from an empty buffer");

    // The fill level never passes the two places of the buffer.
    a_depth_two: assert property (count_q <= COUNT_FULL)
        else $error("buffer holds more than two");

    // An overrun throws the waiting frame away unless a new one lands at once.
    a_overrun_drop: assert property (s_overrun |-> !hold_v_q || $past(frame_valid))
        else $error("waiting frame kept after overrun");

    // The pending overrun must reach the stored entry, not only the mux.
    a_overrun_mark: assert property (dor_pend_q && push |=> buf_q[~wr_ptr_q].dor)
        else $error("overrun not carried to next frame");

    // A clean transfer clears the pending overrun.
    a_dor_clear: assert property (push && !ovr_evt |=> !dor_pend_q)
        else $error("overrun pending after transfer");

    // The stored framing flag is the inverse of the first stop bit.
    a_fe_capture: assert property (
        s_new_frame |=> buf_q[~wr_ptr_q].fe != $past(frame_in.stop_bit))
        else $error("framing flag does not match stop bit");

    // Bits above the selected character size are stored as zero.
    a_data_mask: assert property (
        s_new_frame |=> (buf_q[~wr_ptr_q].data & ~$past(size_mask)) == '0)
        else $error("unused data bits stored as nonzero");

    // With checking off at arrival no parity error is stored.
    a_parity_gate: assert property (
        s_new_frame ##0 !par_en_q |=> !buf_q[~wr_ptr_q].pe)
        else $error("parity error stored with checking off");

    // The status read shows no parity error while checking is off.
    a_parity_off: assert property (
        rd_stb && addr == ADDR_STATUS_A && !par_en_q |=> !rdata_q[ST_PE])
        else $error("parity error shown with checking off");

    // Each data read with no refill in the same cycle takes exactly one entry away.
    a_pop_step: assert property (s_data_read |=> count_q == $past(count_q) - 2'h1)
        else $error("data read did not pop one entry");

    // A register write never pops the buffer, so only one that clears receiver enable can clear flags.
    a_write_no_pop: assert property (wr_stb && rx_en_q |=> $stable(rd_ptr_q))
        else $error("register write moved the buffer");

    // A frame waiting in the shift register is abandoned on disable.
    a_abort_hold: assert property ($fell(rx_en_q) |-> ##[0:1] !hold_v_q)
        else $error("reception kept after disable");

    // The sampling logic sees the disable one cycle later.
    a_enable_copy: assert property (!rx_en_q |=> !rx_enabled_q)
        else $error("sampling logic not told to stop");

    // The pin is handed back while disabled.
    a_pin_release: assert property (!rx_en_q |=> !pin_override_q)
        else $error("pin still overridden while disabled");

    // The pin is claimed while enabled.
    a_pin_claim: assert property (rx_en_q |=> pin_override_q)
        else $error("pin not claimed while enabled");

    // An empty buffer reads as no receive complete.
    a_flag_level: assert property (
        rd_stb && addr == ADDR_STATUS_A && count_q == 2'h0 |=> !rdata_q[ST_RXC])
        else $error("receive complete set on empty buffer");

    // Any unread entry reads as receive complete.
    a_flag_set: assert property (
        rd_stb && addr == ADDR_STATUS_A && count_q != 2'h0 |=> rdata_q[ST_RXC])
        else $error("receive complete clear with unread data");

    // A data read from an empty buffer returns zero.
    a_empty_data: assert property (
        rd_stb && addr == ADDR_DATA && count_q == 2'h0 |=> rdata_q == '0)
        else $error("data returned from an empty buffer");

endmodule
`default_nettype wire

// ==== rub_frame_src.sv ====
// Behavioural model of the remote transmitter side feeding completed frames.
`timescale 1ns/100ps
`default_nettype none
module rub_frame_src
    import rub_pkg::*;
(
    input wire logic ref_clk,
    input wire logic go,
    input wire rub_frame_t fr,
    input wire logic st_req,
    output var logic frame_valid,
    output var rub_frame_t frame_in,
    output var logic start_detect,
    output var logic serial_input_pin
);
    // Idle outputs start at a known level so the first frame is clean.
    initial begin
        frame_valid = 1'b0;
        frame_in = '0;
        start_detect = 1'b0;
        serial_input_pin = 1'b1;
    end
    // A frame is offered only once its first stop bit is in; between frames the
    // payload is inverted so stale data can never pass for a fresh frame.
    always @(posedge ref_clk) begin
        frame_valid <= go;
        frame_in <= go ? fr : ~frame_in;
        start_detect <= st_req;
        serial_input_pin <= ~go;
    end
endmodule
`default_nettype wire

// ==== tb_uart_receive_buffer_status.sv ====
// Self-checking testbench for the receive buffer and status block.
`timescale 1ns/100ps
`default_nettype none
module tb_uart_receive_buffer_status;
    import rub_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic go = 1'b0;
    logic st_req = 1'b0;
    rub_frame_t fr = '0;
    logic [7:0] rdata_q;
    logic frame_valid, start_detect, serial_input_pin;
    rub_frame_t frame_in;
    logic rx_line_q, pin_override_q, rx_enabled_q, rx_irq_q;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;

    rub_frame_src src (.ref_clk(ref_clk), .go(go), .fr(fr), .st_req(st_req),
        .frame_valid(frame_valid), .frame_in(frame_in), .start_detect(start_detect),
        .serial_input_pin(serial_input_pin));
    rub_rx_buffer dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .frame_valid(frame_valid),
        .frame_in(frame_in), .start_detect(start_detect),
        .serial_input_pin(serial_input_pin), .rx_line_q(rx_line_q),
        .pin_override_q(pin_override_q), .rx_enabled_q(rx_enabled_q), .rx_irq_q(rx_irq_q));

    // Clock at 40 MHz.
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe, launched right after an edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    // Read data only stand in the cycle after the strobe, so sample there.
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 chk(rdata_q, e);
    endtask
    task automatic send(input logic [8:0] d, input logic s, input logic p);
        @(posedge ref_clk);
        fr <= '{data: d, stop_bit: s, parity_bit: p};
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(ADDR_STATUS_A, 8'h00);
        rdc(ADDR_CTRL_C, 8'h03);
        rdc(4'h2, 8'h00);
        rdc(ADDR_DATA, 8'h00);
        chk({rx_line_q, pin_override_q, rx_irq_q}, 16'h0004);
        $display("test reset done");
    endtask
    // Frames are ignored while disabled; the irq level follows the flag.
    task automatic t_basic();
        send(9'h0A5, 1'b1, 1'b0);
        settle();
        rdc(ADDR_STATUS_A, 8'h00);
        wr(ADDR_CTRL_B, 8'h90);
        settle();
        chk({pin_override_q, rx_enabled_q}, 16'h0003);
        send(9'h0A5, 1'b1, 1'b0);
        settle();
        chk({rx_irq_q, rx_line_q}, 16'h0002);
        rdc(ADDR_STATUS_A, 8'h80);
        rdc(ADDR_DATA, 8'hA5);
        @(posedge ref_clk);
        #1 chk(rx_irq_q, 16'h0000);
        $display("test basic done");
    endtask
    // Stop select must not matter, status writes are ignored, no irq with its enable off.
    task automatic t_frame();
        wr(ADDR_CTRL_B, 8'h10);
        wr(ADDR_CTRL_C, 8'h0B);
        send(9'h033, 1'b0, 1'b0);
        settle();
        rdc(ADDR_STATUS_A, 8'h90);
        wr(ADDR_STATUS_A, 8'h00);
        rdc(ADDR_STATUS_A, 8'h90);
        chk(rx_irq_q, 16'h0000);
        rdc(ADDR_DATA, 8'h33);
        rdc(ADDR_STATUS_A, 8'h00);
        $display("test framing done");
    endtask
    // Parity table: control c, data, parity bit, expected status.
    localparam logic [7:0] PC[5] = '{8'h23, 8'h23, 8'h33, 8'h33, 8'h03};
    localparam logic [7:0] PD[5] = '{8'h03, 8'h03, 8'h03, 8'h07, 8'h03};
    localparam logic [4:0] PB = 5'b10001;
    localparam logic [7:0] PS[5] = '{8'h84, 8'h80, 8'h84, 8'h80, 8'h80};
    task automatic t_parity();
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL_C, PC[i]);
            send({1'b0, PD[i]}, 1'b1, PB[4-i]);
            settle();
            rdc(ADDR_STATUS_A, PS[i]);
            rdc(ADDR_DATA, PD[i]);
        end
        wr(ADDR_CTRL_C, 8'h23);
        send(9'h003, 1'b1, 1'b1);
        wr(ADDR_CTRL_C, 8'h03);
        rdc(ADDR_STATUS_A, 8'h80);
        rdc(ADDR_DATA, 8'h03);
        $display("test parity done");
    endtask
    // Fill both entries, park a third, lose it to a new start, then drain.
    task automatic t_overrun();
        send(9'h011, 1'b1, 1'b0);
        send(9'h022, 1'b1, 1'b0);
        send(9'h033, 1'b1, 1'b0);
        @(posedge ref_clk);
        st_req <= 1'b1;
        @(posedge ref_clk);
        st_req <= 1'b0;
        send(9'h044, 1'b1, 1'b0);
        settle();
        rdc(ADDR_STATUS_A, 8'h80);
        rdc(ADDR_DATA, 8'h11);
        rdc(ADDR_STATUS_A, 8'h80);
        rdc(ADDR_DATA, 8'h22);
        rdc(ADDR_STATUS_A, 8'h88);
        rdc(ADDR_DATA, 8'h44);
        rdc(ADDR_STATUS_A, 8'h00);
        send(9'h055, 1'b1, 1'b0);
        settle();
        rdc(ADDR_STATUS_A, 8'h80);
        rdc(ADDR_DATA, 8'h55);
        $display("test overrun done");
    endtask
    // Character sizes 5, 6, 7, 8 and 9 bits; all-ones payload, except 155 hex for 9 bits.
    localparam logic [7:0] SC[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
    localparam logic [7:0] SD[5] = '{8'h1F, 8'h3F, 8'h7F, 8'hFF, 8'h55};
    task automatic t_size();
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL_C, SC[i]);
            send((i == 4) ? 9'h155 : 9'h1FF, 1'b1, 1'b0);
            settle();
            rdc(ADDR_STATUS_A, 8'h80);
            rdc(ADDR_CTRL_B, (i == 4) ? 8'h12 : 8'h10);
            rdc(ADDR_DATA, SD[i]);
        end
        $display("test size done");
    endtask
    // Disabling drops both entries at once and releases the pin.
    task automatic t_disable();
        send(9'h0AA, 1'b0, 1'b0);
        send(9'h0BB, 1'b1, 1'b0);
        settle();
        wr(ADDR_CTRL_B, 8'h00);
        settle();
        chk({pin_override_q, rx_enabled_q}, 16'h0000);
        rdc(ADDR_STATUS_A, 8'h00);
        rdc(ADDR_DATA, 8'h00);
        $display("test disable done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Generous ceiling; the whole sequence needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_basic();
        t_frame();
        t_parity();
        t_overrun();
        t_size();
        t_disable();
        wrap_up();
    end
endmodule
`default_nettype wire
